// File: core/walu_defs.svh
`ifndef WALU_DEFS_SVH
`define WALU_DEFS_SVH

// Operation codes from the decoder
`define WALU_OP_ADD 4'h0
`define WALU_OP_ADC 4'h1
`define WALU_OP_SBC 4'h2
`define WALU_OP_INC 4'h3
`define WALU_OP_RR 4'h4
`define WALU_OP_RL 4'h5
`define WALU_OP_AND 4'h6
`define WALU_OP_OR 4'h7
`define WALU_OP_NONZERO_TO_ONE_OP 4'h8
`define WALU_OP_MUL 4'h9
`define WALU_OP_MEM 4'ha
`define WALU_OP_NOP 4'hf

// Destination selects
`define WALU_DST_ACC 2'h0
`define WALU_DST_AUX 2'h1
`define WALU_DST_IX 2'h2
`define WALU_DST_IY 2'h3

// Clock counts
`define WALU_CLK_SHORT 4'h2
`define WALU_CLK_LONG 4'h4
`define WALU_CLK_MUL 4'hc
`define WALU_CLK_WR_INT 4'h2
`define WALU_CLK_WR_EXT 4'h3
`define WALU_CLK_RD 4'h2

// Flag bit positions
`define WALU_FLAG_C 0
`define WALU_FLAG_Z 1
`define WALU_FLAG_S 2
`define WALU_FLAG_V 3

`define WALU_ONE 16'h0001
`define WALU_ZERO16 16'h0000
`define WALU_SPACE_MEM 2'h0
`define WALU_SPACE_IOI 2'h1
`define WALU_SPACE_IOE 2'h2

`endif

// File: core/walu_pkg.sv
package walu_pkg;

    typedef struct packed {
        logic [3:0] op;
        logic [1:0] dst;
        logic [15:0] dst_val;
        logic [15:0] src_val;
        logic [15:0] mpy_val;
        logic carry_in;
        logic alternate_destination_prefix;
        logic two_byte;
    } walu_req_t;

    typedef struct packed {
        logic [1:0] dst;
        logic wr_main;
        logic wr_alt;
        logic [15:0] value;
        logic wr_mpy;
        logic [15:0] mpy_value;
        logic flags_main;
        logic flags_alt;
        logic [3:0] flags;
    } walu_wb_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [1:0] space;
        logic translate;
        logic write;
        logic [7:0] wdata;
    } walu_bus_t;

    typedef enum logic [1:0] {
        WALU_IDLE = 2'b00,
        WALU_BUSY = 2'b01,
        WALU_MUL = 2'b10
    } walu_state_t;

endpackage

// File: core/walu_mul.sv
`timescale 1ns/10ps
`include "walu_defs.svh"

module walu_mul #(
    parameter int STEPS = 12
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Operands
    input wire logic start,
    input wire logic signed [15:0] a,
    input wire logic signed [15:0] b,
    // Result
    output logic done,
    output logic [31:0] product
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [31:0] prod_q;
    logic [31:0] prod_d;
    logic done_q;
    logic done_d;

    always_comb
    begin
        cnt_d = cnt_q;
        prod_d = prod_q;
        done_d = 1'b0;
        if (start)
        begin
            prod_d = 32'(a) * 32'(b);
            // Done comes one clock early, the core registers it once more
            cnt_d = 4'(STEPS - 2);
        end
        else if (cnt_q != 4'h0)
        begin
            cnt_d = cnt_q - 4'h1;
            done_d = (cnt_q == 4'h1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cnt_q <= 4'h0;
            prod_q <= 32'h0000_0000;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            prod_q <= prod_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
    assign product = prod_q;
endmodule

// File: core/walu_core.sv
`timescale 1ns/10ps
`include "walu_defs.svh"

// How it works
// [RQ1] Add, add-with-carry, subtract-with-borrow and increment may target either index register.
// [RQ2] Register increment writes its target and leaves every flag alone.
// [RQ3] The alternate-destination prefix sends the result and flags to the alternate copies.
// [RQ4] Prefixed ops on an index register write the index and send only flags to the alternate.
// [RQ5] Right rotate through carry on acc, aux or index, and aux left rotate; 2 clocks, index 4.
// [RQ6] AND and OR of the aux pair into acc take 2 clocks, into an index register 4 clocks.
// [RQ7] Nonzero-to-one turns a nonzero value into 1, keeps zero, and sets flags from the result.
// [RQ8] Subtract-with-borrow removes source and carry; its carry out is the borrow.
// [RQ9] Signed multiply of multiplier and aux pairs: high to acc, low to multiplier, 12 clocks.
// [RQ10] An I/O prefix turns a memory access into an I/O access at the computed 16-bit address.
// [RQ11] I/O-prefixed accesses bypass address translation.
// [RQ12] Internal I/O writes finish in two clocks, memory and external I/O writes need three.
// [RQ13] Legacy mode: an I/O prefix leaks into a following acc-indexed single-byte op.
// [RQ14] By default the prefix affects only the instruction it precedes.
module walu_core #(
    parameter bit LEGACY_LEAK = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Decoder request
    input wire logic req_valid,
    input wire walu_pkg::walu_req_t req,
    input wire logic [1:0] io_prefix,
    input wire logic acc_indexed,
    input wire logic [15:0] mem_addr,
    input wire logic mem_write,
    input wire logic [7:0] mem_wdata,
    // Status
    output logic busy,
    output logic done,
    // Register file writeback
    output walu_pkg::walu_wb_t wb,
    // Memory and I/O bus
    output logic bus_valid,
    output walu_pkg::walu_bus_t bus
);
    walu_pkg::walu_state_t st_q;
    walu_pkg::walu_state_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    walu_pkg::walu_wb_t wb_q;
    walu_pkg::walu_wb_t wb_d;
    walu_pkg::walu_wb_t res_q;
    walu_pkg::walu_wb_t res_d;
    walu_pkg::walu_bus_t bus_q;
    walu_pkg::walu_bus_t bus_d;
    logic bus_v_q;
    logic bus_v_d;
    logic done_q;
    logic done_d;
    logic busy_q;
    logic busy_d;
    logic [1:0] leak_q;
    logic [1:0] leak_d;
    logic mul_start;
    logic mul_done;
    logic [31:0] mul_prod;
    logic [16:0] sum;
    logic [15:0] val;
    logic [3:0] fl;
    logic upd_flags;
    logic is_idx;
    logic [3:0] len;
    logic [1:0] space;

    walu_mul #(
        .STEPS(int'(`WALU_CLK_MUL))
    ) u_mul (
        .clock(clock),
        .srst(srst),
        .start(mul_start),
        .a(req.mpy_val),
        .b(req.src_val),
        .done(mul_done),
        .product(mul_prod)
    );

    assign is_idx = (req.dst == `WALU_DST_IX) || (req.dst == `WALU_DST_IY);
    assign mul_start = req_valid && (st_q == walu_pkg::WALU_IDLE) && (req.op == `WALU_OP_MUL);

    // Arithmetic and logic result
    always_comb
    begin
        sum = 17'h0_0000;
        val = req.dst_val;
        upd_flags = 1'b1;
        fl = 4'h0;
        unique case (req.op)
            `WALU_OP_ADD: sum = {1'b0, req.dst_val} + {1'b0, req.src_val}; // RQ1
            `WALU_OP_ADC: sum = {1'b0, req.dst_val} + {1'b0, req.src_val} + {16'h0, req.carry_in};
            `WALU_OP_SBC: // RQ8
                sum = {1'b0, req.dst_val} - {1'b0, req.src_val} - {16'h0, req.carry_in};
            `WALU_OP_INC:
            begin
                sum = {1'b0, req.dst_val} + {1'b0, `WALU_ONE};
                upd_flags = 1'b0; // RQ2
            end
            `WALU_OP_RR: sum = {req.dst_val[0], req.carry_in, req.dst_val[15:1]}; // RQ5
            `WALU_OP_RL: sum = {req.dst_val, req.carry_in}; // RQ5
            `WALU_OP_AND: sum = {1'b0, req.dst_val & req.src_val}; // RQ6
            `WALU_OP_OR: sum = {1'b0, req.dst_val | req.src_val}; // RQ6
            `WALU_OP_NONZERO_TO_ONE_OP:
                sum = {1'b0, (req.dst_val != `WALU_ZERO16) ? `WALU_ONE : `WALU_ZERO16}; // RQ7
            default: sum = {1'b0, req.dst_val};
        endcase
        val = sum[15:0];
        fl[`WALU_FLAG_C] = (req.op == `WALU_OP_AND || req.op == `WALU_OP_OR
            || req.op == `WALU_OP_NONZERO_TO_ONE_OP) ? 1'b0 : sum[16]; // RQ8
        fl[`WALU_FLAG_Z] = (val == `WALU_ZERO16); // RQ7
        fl[`WALU_FLAG_S] = val[15];
        fl[`WALU_FLAG_V] = (req.op == `WALU_OP_SBC)
            ? ((req.dst_val[15] != req.src_val[15]) && (val[15] != req.dst_val[15]))
            : ((req.dst_val[15] == req.src_val[15]) && (val[15] != req.dst_val[15]));
    end

    // Bus request: prefix selects space, translation bypassed for I/O
    always_comb
    begin
        space = `WALU_SPACE_MEM;
        if (io_prefix != `WALU_SPACE_MEM)
            space = io_prefix; // RQ10
        else if (LEGACY_LEAK && acc_indexed && (leak_q != `WALU_SPACE_MEM))
            space = leak_q; // RQ13
        len = (mem_write && space != `WALU_SPACE_IOI) ? `WALU_CLK_WR_EXT
            : (mem_write ? `WALU_CLK_WR_INT : `WALU_CLK_RD); // RQ12
        if (req.op != `WALU_OP_MEM && req.op != `WALU_OP_MUL)
            len = req.two_byte ? `WALU_CLK_LONG : `WALU_CLK_SHORT; // RQ5 RQ6
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        res_d = res_q;
        wb_d = wb_q;
        bus_d = bus_q;
        bus_v_d = 1'b0;
        done_d = 1'b0;
        leak_d = leak_q;
        wb_d.wr_main = 1'b0;
        wb_d.wr_alt = 1'b0;
        wb_d.wr_mpy = 1'b0;
        wb_d.flags_main = 1'b0;
        wb_d.flags_alt = 1'b0;
        unique case (st_q)
            walu_pkg::WALU_IDLE:
            begin
                if (req_valid)
                begin
                    // Prefix state lives one instruction only unless legacy mode
                    leak_d = io_prefix; // RQ14
                    res_d.dst = req.dst;
                    res_d.value = val;
                    res_d.flags = fl;
                    res_d.mpy_value = `WALU_ZERO16;
                    res_d.wr_mpy = 1'b0;
                    res_d.wr_main = (req.op != `WALU_OP_MEM) && (!req.alternate_destination_prefix || is_idx); // RQ4
                    res_d.wr_alt = (req.op != `WALU_OP_MEM) && req.alternate_destination_prefix && !is_idx; // RQ3
                    res_d.flags_main = (req.op != `WALU_OP_MEM) && upd_flags && !req.alternate_destination_prefix;
                    res_d.flags_alt = (req.op != `WALU_OP_MEM) && upd_flags && req.alternate_destination_prefix; // RQ3 RQ4
                    if (req.op == `WALU_OP_MEM)
                    begin
                        bus_d.addr = mem_addr; // RQ10
                        bus_d.space = space;
                        bus_d.translate = (space == `WALU_SPACE_MEM); // RQ11 RQ13
                        bus_d.write = mem_write;
                        bus_d.wdata = mem_wdata;
                        bus_v_d = 1'b1;
                    end
                    if (req.op == `WALU_OP_MUL)
                        st_d = walu_pkg::WALU_MUL;
                    else if (len == 4'h1)
                    begin
                        wb_d = res_d;
                        done_d = 1'b1;
                    end
                    else
                    begin
                        st_d = walu_pkg::WALU_BUSY;
                        cnt_d = len - 4'h2;
                    end
                end
            end
            walu_pkg::WALU_BUSY:
            begin
                if (cnt_q == 4'h0)
                begin
                    wb_d = res_q;
                    done_d = 1'b1;
                    st_d = walu_pkg::WALU_IDLE;
                end
                else
                    cnt_d = cnt_q - 4'h1;
            end
            walu_pkg::WALU_MUL:
            begin
                if (mul_done)
                begin
                    wb_d.dst = `WALU_DST_ACC; // RQ9
                    wb_d.value = mul_prod[31:16];
                    wb_d.wr_main = 1'b1;
                    wb_d.wr_mpy = 1'b1;
                    wb_d.mpy_value = mul_prod[15:0];
                    done_d = 1'b1;
                    st_d = walu_pkg::WALU_IDLE;
                end
            end
            default: st_d = walu_pkg::WALU_IDLE;
        endcase
        // Registered so the status output comes from a flop
        busy_d = (st_d != walu_pkg::WALU_IDLE);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_q <= walu_pkg::WALU_IDLE;
            cnt_q <= 4'h0;
            res_q <= '0;
            wb_q <= '0;
            bus_q <= '0;
            bus_v_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            leak_q <= `WALU_SPACE_MEM;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            res_q <= res_d;
            wb_q <= wb_d;
            bus_q <= bus_d;
            bus_v_q <= bus_v_d;
            done_q <= done_d;
            leak_q <= leak_d;
            busy_q <= busy_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign wb = wb_q;
    assign bus_valid = bus_v_q;
    assign bus = bus_q;

    // Checks
    sequence s_short_op;
        req_valid && !busy && !req.two_byte && (req.op == `WALU_OP_AND);
    endsequence

    chk_short_len: assert property (@(posedge clock) disable iff (srst) // RQ6
        s_short_op |-> ##2 done)
        else $error("short op not done in 2 clocks");
    chk_long_len: assert property (@(posedge clock) disable iff (srst) // RQ5
        (req_valid && !busy && req.two_byte && req.op == `WALU_OP_RR)
        |-> ##1 !done [*3] ##1 done)
        else $error("long op not done in 4 clocks");
    chk_mul_len: assert property (@(posedge clock) disable iff (srst) // RQ9
        (req_valid && !busy && req.op == `WALU_OP_MUL) |-> ##12 (done && wb.wr_mpy))
        else $error("multiply timing wrong");
    chk_inc_flags: assert property (@(posedge clock) disable iff (srst) // RQ2
        (req_valid && !busy && req.op == `WALU_OP_INC) |-> ##2 (!wb.flags_main && !wb.flags_alt))
        else $error("increment touched flags");
    chk_alternate_destination_prefix_idx: assert property (@(posedge clock) disable iff (srst) // RQ4
        (req_valid && !busy && req.alternate_destination_prefix && req.dst == `WALU_DST_IX && req.op == `WALU_OP_ADD
        && req.two_byte) |-> ##4 (done && wb.wr_main && !wb.wr_alt && wb.flags_alt))
        else $error("index alternate write wrong");
    chk_alternate_destination_prefix_acc: assert property (@(posedge clock) disable iff (srst) // RQ3
        (req_valid && !busy && req.alternate_destination_prefix && req.dst == `WALU_DST_ACC && req.op == `WALU_OP_ADD
        && req.two_byte) |-> ##4 (done && wb.wr_alt && !wb.wr_main && wb.flags_alt))
        else $error("alternate destination not used");
    chk_io_xlate: assert property (@(posedge clock) disable iff (srst) // RQ11
        (req_valid && !busy && req.op == `WALU_OP_MEM && io_prefix != `WALU_SPACE_MEM)
        |-> ##1 (bus_valid && !bus.translate && bus.space == $past(io_prefix)
        && bus.addr == $past(mem_addr)))
        else $error("io access translated");
    chk_nonzero_to_one_op_val: assert property (@(posedge clock) disable iff (srst) // RQ7
        (req_valid && !busy && req.op == `WALU_OP_NONZERO_TO_ONE_OP && req.dst_val != 16'h0000 && !req.two_byte)
        |-> ##2 (wb.value == 16'h0001))
        else $error("nonzero to one wrong");
    chk_no_leak: assert property (@(posedge clock) disable iff (srst) // RQ14
        (!LEGACY_LEAK && req_valid && !busy && req.op == `WALU_OP_MEM && io_prefix == 2'h0)
        |-> ##1 (bus_valid && bus.translate))
        else $error("prefix leaked");
    chk_wr_int: assert property (@(posedge clock) disable iff (srst) // RQ12
        (req_valid && !busy && req.op == `WALU_OP_MEM && mem_write && io_prefix == `WALU_SPACE_IOI)
        |-> ##2 done)
        else $error("internal write not two clocks");
    chk_sbc_borrow: assert property (@(posedge clock) disable iff (srst) // RQ8
        (req_valid && !busy && req.op == `WALU_OP_SBC && !req.two_byte && req.carry_in
        && req.dst_val == req.src_val) |-> ##2 (done && wb.flags[`WALU_FLAG_C]))
        else $error("borrow not reported");
    chk_idx_dst: assert property (@(posedge clock) disable iff (srst) // RQ1
        (req_valid && !busy && req.op == `WALU_OP_ADC && req.dst == `WALU_DST_IY
        && req.two_byte) |-> ##4 (done && wb.wr_main && wb.dst == `WALU_DST_IY))
        else $error("index destination not written");
endmodule

// File: bench/walu_iodev.sv
`timescale 1ns/10ps

module walu_iodev (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Access from the block
    input wire logic bus_valid,
    input wire walu_pkg::walu_bus_t bus,
    // Observation for the bench
    output walu_pkg::walu_bus_t last,
    output logic [7:0] count,
    output logic [7:0] rdata
);
    // One byte store for each of spaces 0 to 2, so memory and I/O stay apart
    logic [7:0] store [3][256];

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            count <= 8'h00;
            last <= '0;
        end
        else if (bus_valid)
        begin
            count <= count + 8'h01;
            last <= bus;
            if (bus.write && bus.space != 2'h3)
                store[bus.space][bus.addr[7:0]] <= bus.wdata;
        end
    end

    // A read in space 3, which has no store, shows the inverted write data of the last access
    assign rdata = (last.space == 2'h3) ? ~last.wdata : store[last.space][last.addr[7:0]];
endmodule

// File: bench/test_word_alu_and_io_prefix.sv
`timescale 1ns/10ps
`include "walu_defs.svh"

module test_word_alu_and_io_prefix;
    logic clock;
    logic srst;
    logic req_valid;
    walu_pkg::walu_req_t req;
    logic [1:0] io_prefix;
    logic acc_indexed;
    logic [15:0] mem_addr;
    logic mem_write;
    logic [7:0] mem_wdata;
    logic busy;
    logic done;
    logic bus_valid;
    logic bus_valid_leak;
    walu_pkg::walu_wb_t wb;
    walu_pkg::walu_bus_t bus;
    walu_pkg::walu_bus_t bus_leak;
    walu_pkg::walu_bus_t dev_last;
    logic [7:0] dev_count;
    logic [7:0] dev_rdata;
    int errors;
    int check_count;
    int n;

    walu_core u_dut (.clock(clock), .srst(srst), .req_valid(req_valid), .req(req),
        .io_prefix(io_prefix), .acc_indexed(acc_indexed), .mem_addr(mem_addr),
        .mem_write(mem_write), .mem_wdata(mem_wdata), .busy(busy), .done(done), .wb(wb),
        .bus_valid(bus_valid), .bus(bus));

    // Second copy built with the observed prefix leak
    walu_core #(.LEGACY_LEAK(1'b1)) u_dut_leak (.clock(clock), .srst(srst),
        .req_valid(req_valid), .req(req), .io_prefix(io_prefix), .acc_indexed(acc_indexed),
        .mem_addr(mem_addr), .mem_write(mem_write), .mem_wdata(mem_wdata), .busy(),
        .done(), .wb(), .bus_valid(bus_valid_leak), .bus(bus_leak));

    walu_iodev u_dev (.clock(clock), .srst(srst), .bus_valid(bus_valid), .bus(bus),
        .last(dev_last), .count(dev_count), .rdata(dev_rdata));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic op(input logic [3:0] o, input logic [1:0] d, input logic [15:0] dv,
        input logic [15:0] sv, input logic [15:0] mv, input logic cin, input logic alt,
        input logic two, input int len);
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{op:o, dst:d, dst_val:dv, src_val:sv, mpy_val:mv, carry_in:cin, alternate_destination_prefix:alt,
            two_byte:two};
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        // Read at the edge itself, before that edge's updates land
        do
        begin
            @(posedge clock);
            n++;
            if (n == 1)
                chk("busy", busy, 1'b1);
        end
        while (done !== 1'b1 && n < 20);
        chk("latency", n, len);
    endtask

    task automatic exp_wb(input string nm, input logic [1:0] d, input logic [15:0] v,
        input logic c);
        chk(nm, {wb.dst, wb.wr_main, wb.value, wb.flags[`WALU_FLAG_C]}, {d, 1'b1, v, c});
    endtask

    task automatic t_arith;
        logic [1:0] d;
        logic [16:0] r;
        int len;
        for (int k = 0; k < 3; k++)
        begin
            d = (k == 0) ? `WALU_DST_ACC : (k == 1) ? `WALU_DST_IX : `WALU_DST_IY;
            len = (k == 0) ? 2 : 4;
            r = {1'b0, 16'hf000} + 17'h02345;
            op(`WALU_OP_ADD, d, 16'hf000, 16'h2345, 16'h0000, 1'b0, 1'b0, k != 0, len);
            exp_wb("add", d, r[15:0], r[16]);
            op(`WALU_OP_ADC, d, 16'hffff, 16'h0000, 16'h0000, 1'b1, 1'b0, k != 0, len);
            exp_wb("adc", d, 16'h0000, 1'b1);
            r = {1'b0, 16'h1000} - {1'b0, 16'h1000} - 17'h00001;
            op(`WALU_OP_SBC, d, 16'h1000, 16'h1000, 16'h0000, 1'b1, 1'b0, k != 0, len);
            exp_wb("sbc", d, r[15:0], r[16]);
            chk("sbc_sv", {wb.flags[`WALU_FLAG_S], wb.flags[`WALU_FLAG_V]}, 2'b10);
            op(`WALU_OP_INC, d, 16'hffff, 16'h0000, 16'h0000, 1'b0, 1'b0, k != 0, len);
            chk("inc", {wb.dst, wb.wr_main, wb.value, wb.flags_main, wb.flags_alt},
                {d, 1'b1, 16'h0000, 2'b00});
        end
        op(`WALU_OP_SBC, `WALU_DST_ACC, 16'h0005, 16'h0002, 16'h0000, 1'b0, 1'b0, 1'b0, 2);
        exp_wb("sbc_nb", `WALU_DST_ACC, 16'h0003, 1'b0);
    endtask

    task automatic t_alternate_destination_prefix;
        op(`WALU_OP_ADD, `WALU_DST_ACC, 16'h0001, 16'h0002, 16'h0000, 1'b0, 1'b1, 1'b1, 4);
        chk("alternate_destination_prefix_acc", {wb.value, wb.wr_main, wb.wr_alt, wb.flags_main, wb.flags_alt},
            {16'h0003, 4'b0101});
        op(`WALU_OP_ADD, `WALU_DST_IX, 16'h0001, 16'h0002, 16'h0000, 1'b0, 1'b1, 1'b1, 4);
        chk("alternate_destination_prefix_ix", {wb.value, wb.wr_main, wb.wr_alt, wb.flags_main, wb.flags_alt},
            {16'h0003, 4'b1001});
        op(`WALU_OP_NONZERO_TO_ONE_OP, `WALU_DST_IY, 16'h0300, 16'h0000, 16'h0000, 1'b0, 1'b1, 1'b1, 4);
        chk("alternate_destination_prefix_iy", {wb.value, wb.wr_main, wb.wr_alt, wb.flags_main, wb.flags_alt},
            {16'h0001, 4'b1001});
    endtask

    task automatic t_rot;
        logic [3:0] o;
        logic [1:0] d;
        for (int k = 0; k < 5; k++)
        begin
            o = (k == 2) ? `WALU_OP_RL : `WALU_OP_RR;
            d = (k == 0) ? `WALU_DST_ACC : (k < 3) ? `WALU_DST_AUX : (k == 3) ? `WALU_DST_IX
                : `WALU_DST_IY;
            op(o, d, 16'h8001, 16'h0000, 16'h0000, 1'b1, 1'b0, k > 2, (k > 2) ? 4 : 2);
            exp_wb("rot", d, (k == 2) ? 16'h0003 : 16'hc000, 1'b1);
        end
    endtask

    task automatic t_logic;
        logic [1:0] d;
        for (int k = 0; k < 6; k++)
        begin
            d = (k % 3 == 0) ? `WALU_DST_ACC : (k % 3 == 1) ? `WALU_DST_IX : `WALU_DST_IY;
            op((k < 3) ? `WALU_OP_AND : `WALU_OP_OR, d, 16'hf0f0, 16'h3c3c, 16'h0000, 1'b1,
                1'b0, k % 3 != 0, (k % 3 != 0) ? 4 : 2);
            exp_wb("logic", d, (k < 3) ? 16'h3030 : 16'hfcfc, 1'b0);
        end
    endtask

    task automatic t_nonzero_to_one_op;
        op(`WALU_OP_NONZERO_TO_ONE_OP, `WALU_DST_ACC, 16'h8000, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0, 2);
        exp_wb("nonzero_to_one_op_nz", `WALU_DST_ACC, 16'h0001, 1'b0);
        chk("nonzero_to_one_op_nz_z", wb.flags[`WALU_FLAG_Z], 1'b0);
        op(`WALU_OP_NONZERO_TO_ONE_OP, `WALU_DST_IX, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b1, 4);
        exp_wb("nonzero_to_one_op_z", `WALU_DST_IX, 16'h0000, 1'b0);
        chk("nonzero_to_one_op_z_z", wb.flags[`WALU_FLAG_Z], 1'b1);
    endtask

    task automatic t_mul;
        op(`WALU_OP_MUL, `WALU_DST_ACC, 16'h0000, 16'h03e8, 16'hfffd, 1'b0, 1'b0, 1'b0, 12);
        chk("mul_neg", {wb.value, wb.mpy_value}, 32'hfffff448);
        chk("mul_wr", {wb.wr_main, wb.wr_mpy}, 2'b11);
        op(`WALU_OP_MUL, `WALU_DST_ACC, 16'h0000, 16'h8000, 16'h8000, 1'b0, 1'b0, 1'b0, 12);
        chk("mul_min", {wb.value, wb.mpy_value}, 32'h40000000);
    endtask

    task automatic mem_op(input logic [1:0] sp, input logic wr, input logic idx, input int len);
        io_prefix <= sp;
        acc_indexed <= idx;
        mem_addr <= 16'h4005 + {14'h0000, sp};
        mem_write <= wr;
        mem_wdata <= 8'h5a ^ {6'h00, sp};
        op(`WALU_OP_MEM, `WALU_DST_ACC, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, len);
    endtask

    task automatic t_io;
        logic [7:0] c0;
        for (int k = 0; k < 3; k++)
        begin
            c0 = dev_count;
            mem_op(k[1:0], 1'b1, 1'b0, (k == 1) ? 2 : 3);
            chk("io_wr", dev_last, {16'h4005 + k[15:0], k[1:0], k == 0, 1'b1,
                8'h5a ^ k[7:0]});
            chk("io_cnt", dev_count, c0 + 8'h01);
        end
        mem_op(`WALU_SPACE_IOI, 1'b0, 1'b0, 2);
        chk("io_rd", {dev_last.space, dev_last.translate, dev_last.write},
            {`WALU_SPACE_IOI, 2'b00});
        chk("io_rd_data", dev_rdata, 8'h5b);
    endtask

    task automatic t_leak;
        mem_op(`WALU_SPACE_IOE, 1'b1, 1'b0, 3);
        mem_op(`WALU_SPACE_MEM, 1'b0, 1'b1, 2);
        chk("fixed", {bus.space, bus.translate}, {`WALU_SPACE_MEM, 1'b1});
        chk("leak", {bus_leak.space, bus_leak.translate}, {`WALU_SPACE_IOE, 1'b0});
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clock);
        errors++;
        tally_and_finish();
    end

    initial
    begin
        errors = 0;
        check_count = 0;
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        io_prefix = 2'h0;
        acc_indexed = 1'b0;
        mem_addr = 16'h0000;
        mem_write = 1'b0;
        mem_wdata = 8'h00;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        t_arith();
        t_alternate_destination_prefix();
        t_rot();
        t_logic();
        t_nonzero_to_one_op();
        t_mul();
        t_io();
        t_leak();
        tally_and_finish();
    end
endmodule
